// >>> rtl/flash_host_pkg.sv
/*
 * Shared constants and types for the flash command sequencer on the host side.
 * It assumes a 25 MHz controller clock and a parallel NOR flash that is driven
 * by asynchronous write and read cycles with active-low strobes.
 */
package flash_host_pkg;

    // Bus widths and the depth of the host-side word store
    localparam int ADDR_W  = 22;
    localparam int DATA_W  = 16;
    localparam int STORE_N = 16;
    localparam int IDX_W   = 4;
    localparam int STEP_W  = 5;
    localparam int CNT_W   = 4;

    // Clock period and bus-cycle times in ns; cycle counts round up
    localparam int CLK_NS    = 40;
    localparam int WE_LOW_NS = 35;
    localparam int RD_ACC_NS = 90;
    localparam logic [CNT_W-1:0] WE_LOW_CYC =
        CNT_W'((WE_LOW_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 : (WE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RD_ACC_CYC =
        CNT_W'((RD_ACC_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 : (RD_ACC_NS + CLK_NS - 1) / CLK_NS);

    // Unlock addresses: word-mode protection set and byte-mode command set
    localparam logic [ADDR_W-1:0] A_WORD_UNLOCK1 = 22'h000555;
    localparam logic [ADDR_W-1:0] A_WORD_UNLOCK2 = 22'h0002aa;
    localparam logic [ADDR_W-1:0] A_BYTE_UNLOCK1 = 22'h000aaa;
    localparam logic [ADDR_W-1:0] A_BYTE_UNLOCK2 = 22'h000555;
    localparam logic [ADDR_W-1:0] A_ANY          = 22'h000000;

    // Command data values
    localparam logic [DATA_W-1:0] D_UNLOCK1      = 16'h00aa;
    localparam logic [DATA_W-1:0] D_UNLOCK2      = 16'h0055;
    localparam logic [DATA_W-1:0] D_FREEZE_ENTRY = 16'h0050;
    localparam logic [DATA_W-1:0] D_DYN_ENTRY    = 16'h00e0;
    localparam logic [DATA_W-1:0] D_PWD_ENTRY    = 16'h0060;
    localparam logic [DATA_W-1:0] D_SETUP        = 16'h00a0;
    localparam logic [DATA_W-1:0] D_EXIT         = 16'h0090;
    localparam logic [DATA_W-1:0] D_ZERO         = 16'h0000;
    localparam logic [DATA_W-1:0] D_UNPROTECT    = 16'h0001;
    localparam logic [DATA_W-1:0] D_RESET        = 16'h00f0;
    localparam logic [DATA_W-1:0] D_AUTOSELECT   = 16'h0090;
    localparam logic [DATA_W-1:0] D_SECURE       = 16'h0088;
    localparam logic [DATA_W-1:0] D_BUF_LOAD     = 16'h0025;
    localparam logic [DATA_W-1:0] D_PWD_KEY      = 16'h0003;
    localparam logic [DATA_W-1:0] D_BUF_COMMIT   = 16'h0029;

    // Entry length, body lengths of the protection commands, and first buffer-word step
    localparam logic [STEP_W-1:0] ENTRY_LEN   = 5'h03;
    localparam logic [STEP_W-1:0] PWD_WORDS   = 5'h04;
    localparam logic [STEP_W-1:0] UNLOCK_BODY = 5'h07;
    localparam logic [STEP_W-1:0] BUF_FIRST   = 5'h04;

    // Orders taken at the user port
    typedef enum logic [3:0] {
        OP_READ, OP_RESET, OP_FREEZE_SET, OP_FREEZE_READ, OP_DYN_PROTECT,
        OP_DYN_UNPROTECT, OP_DYN_READ, OP_PWD_PROGRAM, OP_PWD_READ, OP_PWD_UNLOCK,
        OP_AUTOSEL_READ, OP_SECURE_ENTER, OP_SECURE_EXIT, OP_BUF_PROGRAM, OP_BUF_ABORT_RESET
    } op_t;

    // One bus cycle of a sequence
    typedef enum logic [1:0] {K_WRITE, K_READ, K_DONE} kind_t;

    // Phases of one bus cycle
    typedef enum logic [2:0] {P_IDLE, P_PREP, P_LOAD, P_SETUP, P_STROBE, P_HOLD} phase_t;

endpackage

// >>> rtl/flash_host_store.sv
/*
 * Small word store holding password portions and write-buffer words.
 * Assumes one write port from the user and one read port from the sequencer;
 * read data come out of a register one clock after the index.
 */
`timescale 1ns/1ns
module flash_host_store
    import flash_host_pkg::*;
(
    input  wire logic              mclk,     // Controller clock
    input  wire logic              wr_en,    // Write strobe
    input  wire logic [IDX_W-1:0]  wr_idx,   // Write index
    input  wire logic [DATA_W-1:0] wr_data,  // Write word
    input  wire logic [IDX_W-1:0]  rd_idx,   // Read index
    output logic      [DATA_W-1:0] rd_data   // Registered read word
);

    logic [DATA_W-1:0] mem [STORE_N];

    // Write port and registered read port
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= mem[rd_idx];
    end

endmodule // flash_host_store

// >>> rtl/flash_host_seq.sv
/*
 * Host-side controller that issues flash command sequences over the parallel
 * bus pins: protection freeze, dynamic protection, password, autoselect,
 * secured region, write-buffer programming, reset and plain reads.
 * Assumes the flash pins are synchronous to mclk and the testbench resolves
 * the data wires from dq_oe_n. Orders arrive on a valid/ready user port.
 */
// Notes on behaviour
// - Freeze entry 555/AA, 2AA/55, 555/50; A0 then 00 sets lock; read bit 0.
// - Dynamic mode entry E0; A0 then sector address with 00 protect, 01 unprotect.
// - Host never writes wrong values or out-of-order cycles.
// - Protection instructions follow the matching three-cycle entry.
// - Protection modes are left by 90 then 00.
// - Each password portion is programmed by A0 then its address and data.
// - Password reads drive the full address.
// - Unlock sends 25, 03, all four portions, then 29.
// - Single F0 write resets the device to array read.
// - Byte-mode autoselect AAA/AA, 555/55, AAA/90, then one read, then an F0 write.
// - Byte-mode AAA/AA, 555/55, AAA/88 enters the secured region.
// - Secured region left by AA, 55, 90, then any address with 00.
// - Buffer load AA, 55, sector/25, sector/count, then words.
// - Sector address with 29 commits the buffer.
// - AAA/AA, 555/55, AAA/F0 clears an aborted buffer load.
// - Location count is number of buffer words minus one.
`timescale 1ns/1ns
module flash_host_seq
    import flash_host_pkg::*;
(
    input  wire logic              mclk,          // Controller clock, 25 MHz
    input  wire logic              rst,           // Synchronous reset, active high
    input  wire logic              cmd_valid,     // Order offered
    output logic                   cmd_ready,     // Order taken when idle
    input  op_t                    cmd_op,        // Which sequence to run
    input  wire logic [ADDR_W-1:0] cmd_addr,      // Sector, read or program address
    input  wire logic [DATA_W-1:0] cmd_data,      // Password portion data
    input  wire logic [IDX_W-1:0]  cmd_count,     // Buffer words minus one
    input  wire logic              store_wr_en,   // Store write strobe
    input  wire logic [IDX_W-1:0]  store_wr_idx,  // Store write index
    input  wire logic [DATA_W-1:0] store_wr_data, // Store write word
    output logic                   rsp_valid,     // Read word ready, one cycle
    output logic      [DATA_W-1:0] rsp_data,      // Word read from the flash
    output logic                   rsp_protected, // Status bit 0 read low
    output logic                   busy,          // Sequence in progress
    output logic      [ADDR_W-1:0] flash_addr,    // Flash address pins
    output logic      [DATA_W-1:0] flash_dq_out,  // Flash data driven
    input  wire logic [DATA_W-1:0] flash_dq_in,   // Flash data sampled
    output logic                   flash_dq_oe_n, // Data drive enable, low drives
    output logic                   flash_ce_n,    // Chip enable
    output logic                   flash_we_n,    // Write strobe
    output logic                   flash_oe_n     // Output enable
);

    typedef struct packed {
        phase_t            phase;
        op_t               op;
        logic [STEP_W-1:0] step;
        logic [CNT_W-1:0]  cnt;
        logic              is_read;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [IDX_W-1:0]  count;
        logic              rsp_valid;
        logic [DATA_W-1:0] rsp_data;
        logic              rsp_protected;
        logic [ADDR_W-1:0] fa;
        logic [DATA_W-1:0] dq_o;
        logic              dq_oe_n;
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
    } state_t;

    state_t            s;
    state_t            next_s;
    kind_t             st_kind;
    logic [ADDR_W-1:0] st_addr;
    logic [DATA_W-1:0] st_data;
    logic [IDX_W-1:0]  rd_idx;
    logic [DATA_W-1:0] rd_word;
    logic [STEP_W-1:0] b;
    logic [STEP_W-1:0] blen;
    logic [STEP_W-1:0] buf_end;

    // Word store for password portions and buffer words
    flash_host_store u_store (
        .mclk    (mclk),
        .wr_en   (store_wr_en),
        .wr_idx  (store_wr_idx),
        .wr_data (store_wr_data),
        .rd_idx  (rd_idx),
        .rd_data (rd_word)
    );

    // Store index follows the step: unlock portions from step 5, buffer words from step 4
    assign rd_idx = (s.op == OP_PWD_UNLOCK) ? IDX_W'(s.step - 5'h05) : IDX_W'(s.step - BUF_FIRST);

    // Body position of protection commands and last buffer step
    assign b       = s.step - ENTRY_LEN;
    assign buf_end = BUF_FIRST + {1'b0, s.count};

    // Body length of each protection command, exit follows it
    always_comb begin
        case (s.op)
            OP_FREEZE_READ, OP_DYN_READ: blen = 5'h01;
            OP_PWD_READ:                 blen = PWD_WORDS;
            OP_PWD_UNLOCK:               blen = UNLOCK_BODY;
            default:                     blen = 5'h02;
        endcase
    end

    always_comb begin
        st_kind = K_DONE;
        st_addr = A_ANY;
        st_data = D_ZERO;
        case (s.op)
            OP_READ: begin
                if (s.step == 5'h00) begin
                    st_kind = K_READ;
                    st_addr = s.addr;
                end
            end
            OP_RESET: begin
                if (s.step == 5'h00) begin
                    st_kind = K_WRITE;
                    st_data = D_RESET;
                end
            end
            OP_FREEZE_SET, OP_FREEZE_READ, OP_DYN_PROTECT, OP_DYN_UNPROTECT, OP_DYN_READ,
            OP_PWD_PROGRAM, OP_PWD_READ, OP_PWD_UNLOCK: begin
                if (s.step < ENTRY_LEN) begin
                    st_kind = K_WRITE;
                    st_addr = (s.step == 5'h01) ? A_WORD_UNLOCK2 : A_WORD_UNLOCK1;
                    if (s.step == 5'h00) begin
                        st_data = D_UNLOCK1;
                    end else if (s.step == 5'h01) begin
                        st_data = D_UNLOCK2;
                    end else if (s.op == OP_FREEZE_SET || s.op == OP_FREEZE_READ) begin
                        st_data = D_FREEZE_ENTRY;
                    end else if (s.op == OP_PWD_PROGRAM || s.op == OP_PWD_READ || s.op == OP_PWD_UNLOCK) begin
                        st_data = D_PWD_ENTRY;
                    end else begin
                        st_data = D_DYN_ENTRY;
                    end
                end else if (b < blen) begin
                    st_kind = K_WRITE;
                    case (s.op)
                        OP_FREEZE_SET:  st_data = (b == 5'h00) ? D_SETUP : D_ZERO;
                        OP_FREEZE_READ: st_kind = K_READ;
                        OP_DYN_PROTECT, OP_DYN_UNPROTECT: begin
                            st_addr = (b == 5'h00) ? A_ANY : s.addr;
                            if (b == 5'h00) begin
                                st_data = D_SETUP;
                            end else begin
                                st_data = (s.op == OP_DYN_PROTECT) ? D_ZERO : D_UNPROTECT;
                            end
                        end
                        OP_DYN_READ: begin
                            st_kind = K_READ;
                            st_addr = s.addr;
                        end
                        OP_PWD_PROGRAM: begin
                            st_addr = (b == 5'h00) ? A_ANY : {20'h00000, s.addr[1:0]};
                            st_data = (b == 5'h00) ? D_SETUP : s.data;
                        end
                        OP_PWD_READ: begin
                            st_kind = K_READ;
                            st_addr = {20'h00000, b[1:0]};
                        end
                        default: begin
                            if (b == 5'h00) begin
                                st_data = D_BUF_LOAD;
                            end else if (b == 5'h01) begin
                                st_data = D_PWD_KEY;
                            end else if (b == 5'h06) begin
                                st_data = D_BUF_COMMIT;
                            end else begin
                                st_addr = {20'h00000, 2'(b - 5'h02)};
                                st_data = rd_word;
                            end
                        end
                    endcase
                end else if (b == blen) begin
                    st_kind = K_WRITE;
                    st_data = D_EXIT;
                end else if (b == blen + 5'h01) begin
                    st_kind = K_WRITE;
                    st_data = D_ZERO;
                end
            end
            default: begin
                if (s.step < 5'h02) begin
                    // Byte-mode unlock pair
                    st_kind = K_WRITE;
                    st_addr = (s.step == 5'h00) ? A_BYTE_UNLOCK1 : A_BYTE_UNLOCK2;
                    st_data = (s.step == 5'h00) ? D_UNLOCK1 : D_UNLOCK2;
                end else if (s.step == 5'h02) begin
                    st_kind = K_WRITE;
                    st_addr = A_BYTE_UNLOCK1;
                    case (s.op)
                        OP_AUTOSEL_READ:    st_data = D_AUTOSELECT;
                        OP_SECURE_ENTER:    st_data = D_SECURE;
                        OP_SECURE_EXIT:     st_data = D_AUTOSELECT;
                        OP_BUF_ABORT_RESET: st_data = D_RESET;
                        default: begin
                            st_addr = s.addr;
                            st_data = D_BUF_LOAD;
                        end
                    endcase
                end else if (s.op == OP_AUTOSEL_READ) begin
                    if (s.step == 5'h03) begin
                        st_kind = K_READ;
                        st_addr = s.addr;
                    end else if (s.step == 5'h04) begin
                        st_kind = K_WRITE;
                        st_data = D_RESET;
                    end
                end else if (s.op == OP_SECURE_EXIT) begin
                    if (s.step == 5'h03) begin
                        st_kind = K_WRITE;
                        st_data = D_ZERO;
                    end
                end else if (s.op == OP_BUF_PROGRAM) begin
                    if (s.step == 5'h03) begin
                        st_kind = K_WRITE;
                        st_addr = s.addr;
                        st_data = {12'h000, s.count};
                    end else if (s.step <= buf_end) begin
                        st_kind = K_WRITE;
                        st_addr = s.addr + ADDR_W'(s.step - BUF_FIRST);
                        st_data = rd_word;
                    end else if (s.step == buf_end + 5'h01) begin
                        st_kind = K_WRITE;
                        st_addr = s.addr;
                        st_data = D_BUF_COMMIT;
                    end
                end
            end
        endcase
    end

    // Bus cycle engine
    always_comb begin
        next_s = s;
        next_s.rsp_valid = 1'b0;
        case (s.phase)
            P_IDLE: begin
                if (cmd_valid) begin
                    next_s.op    = cmd_op;
                    next_s.addr  = cmd_addr;
                    next_s.data  = cmd_data;
                    next_s.count = cmd_count;
                    next_s.step  = 5'h00;
                    next_s.phase = P_PREP;
                end
            end
            P_PREP: next_s.phase = P_LOAD;
            P_LOAD: begin
                if (st_kind == K_DONE) begin
                    next_s.phase = P_IDLE;
                end else begin
                    // each cycle framed by chip enable
                    next_s.is_read = (st_kind == K_READ);
                    next_s.fa      = st_addr;
                    next_s.dq_o    = st_data;
                    next_s.dq_oe_n = (st_kind == K_READ);
                    next_s.ce_n    = 1'b0;
                    next_s.phase   = P_SETUP;
                end
            end
            P_SETUP: begin
                next_s.cnt   = '0;
                next_s.oe_n  = ~s.is_read;
                next_s.we_n  = s.is_read;
                next_s.phase = P_STROBE;
            end
            P_STROBE: begin
                next_s.cnt = s.cnt + 4'h1;
                if (s.is_read && s.cnt == RD_ACC_CYC - 4'h1) begin
                    next_s.rsp_data      = flash_dq_in;
                    next_s.rsp_protected = ~flash_dq_in[0];
                    next_s.rsp_valid     = 1'b1;
                    next_s.oe_n          = 1'b1;
                    next_s.phase         = P_HOLD;
                end else if (!s.is_read && s.cnt == WE_LOW_CYC - 4'h1) begin
                    next_s.we_n  = 1'b1;
                    next_s.phase = P_HOLD;
                end
            end
            default: begin
                next_s.ce_n    = 1'b1;
                next_s.dq_oe_n = 1'b1;
                next_s.step    = s.step + 5'h01;
                next_s.phase   = P_PREP;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s         <= '0;
            s.phase   <= P_IDLE;
            s.op      <= OP_READ;
            s.dq_oe_n <= 1'b1;
            s.ce_n    <= 1'b1;
            s.we_n    <= 1'b1;
            s.oe_n    <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign cmd_ready     = (s.phase == P_IDLE);
    assign busy          = (s.phase != P_IDLE);
    assign rsp_valid     = s.rsp_valid;
    assign rsp_data      = s.rsp_data;
    assign rsp_protected = s.rsp_protected;
    assign flash_addr    = s.fa;
    assign flash_dq_out  = s.dq_o;
    assign flash_dq_oe_n = s.dq_oe_n;
    assign flash_ce_n    = s.ce_n;
    assign flash_we_n    = s.we_n;
    assign flash_oe_n    = s.oe_n;

endmodule // flash_host_seq

// >>> dv/flash_dev_model.sv
/* Behavioural flash device seen by the host sequencer.
   Assumes the bench resolves the data wire and hands it in as din. */
`timescale 1ns/1ns
module flash_dev_model
    import flash_host_pkg::*;
#(parameter logic [DATA_W-1:0] MAKER = 16'h00c3) // Arbitrary maker code
(
    input  wire logic [ADDR_W-1:0] addr, // Address pins
    input  wire logic [DATA_W-1:0] din,  // Resolved data wire
    output logic      [DATA_W-1:0] dout, // Data offered to host
    input  wire logic              ce_n, // Chip enable
    input  wire logic              we_n, // Write strobe
    input  wire logic              oe_n  // Output enable
);
    // Modes: 0 array, 1 freeze, 2 dynamic, 3 password, 4 autoselect, 5 secure, 6 buffer
    logic [2:0]        mode = 0;
    logic [7:0]        h1 = 0, h2 = 0;
    logic              arm = 0, ex = 0, lock = 0, ok = 0;
    logic [127:0]      dyn = '1;
    logic [DATA_W-1:0] pw [4] = '{default: 0};
    logic [DATA_W-1:0] val, last = 0;
    logic [4:0]        uc = 0, nb = 0, done_n = 0;
    wire  [7:0]        c = din[7:0];

    // Command decoder, one step per write strobe
    // mode tracking
    always @(posedge we_n) if (!ce_n) begin
        h2 <= h1;
        h1 <= c;
        if (arm) begin
            arm <= 0;
            if (mode == 1) lock <= 1;
            if (mode == 2) dyn[addr[21:15]] <= c[0];
            if (mode == 3) pw[addr[1:0]] <= din;
        end else if (mode == 6) begin
            if (c == 8'h29) done_n <= nb;
            if (c == 8'h29) mode <= 0;
            else nb <= nb + 1;
        end else if (c == 8'hf0) mode <= 0;
        else if (h2 == 8'haa && h1 == 8'h55) begin
            case (c)
                8'h50: mode <= 1;
                8'he0: mode <= 2;
                8'h60: mode <= 3;
                8'h90: mode <= 4;
                8'h88: mode <= 5;
                8'h25: begin mode <= 6; nb <= '1; end
                default: ;
            endcase
        end else if (c == 8'ha0 && mode inside {1, 2, 3}) arm <= 1;
        else if (c == 8'h90 && mode != 0) ex <= 1;
        else if (c == 8'h00 && (ex || mode == 4)) begin mode <= 0; ex <= 0; end
        else if (mode == 3 && c == 8'h25) uc <= 0;
        else if (mode == 3 && c == 8'h29) ok <= (uc == 5);
        else if (mode == 3) uc <= uc + 5'(c == 8'h03 || din == pw[addr[1:0]]);
    end

    // read data by mode, status high when unprotected, password only at full address
    always_comb case (mode)
        1: val = {15'h0, ~lock};
        2: val = {15'h0, dyn[addr[21:15]]};
        3: val = (addr[21:2] == 20'h0) ? pw[addr[1:0]] : ~pw[addr[1:0]];
        4: val = (addr[7:0] == 8'h00) ? MAKER : 16'h0000;
        5: val = ~addr[15:0];
        default: val = addr[15:0] ^ 16'h5a5a;
    endcase
    // Released wire shows the inverse of the last word
    always @(posedge oe_n) last <= val;
    assign dout = (!ce_n && !oe_n) ? val : ~last;
endmodule // flash_dev_model

// >>> dv/flash_host_seq_monitor.sv
/* Concurrent checks on the host sequencer's pins.
   Assumes binding into flash_host_seq, one clock domain. */
`timescale 1ns/1ns
module flash_host_seq_monitor
    import flash_host_pkg::*;
(
    input wire logic              mclk, rst, cmd_valid, cmd_ready, // Clock, reset, order port
    input wire logic              rsp_valid, rsp_protected, busy,  // Answer flags
    input wire logic [DATA_W-1:0] rsp_data, flash_dq_out,          // Data words
    input wire logic [ADDR_W-1:0] flash_addr,                      // Address pins
    input wire logic              flash_dq_oe_n, flash_ce_n,       // Drive and chip enables
    input wire logic              flash_we_n, flash_oe_n           // Strobes
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Read strobe held three clocks, answer as it ends
    sequence read_strobe;
        !flash_oe_n ##1 !flash_oe_n ##1 (flash_oe_n && rsp_valid);
    endsequence

    a_we_needs_ce: assert property (!flash_we_n |-> !flash_ce_n)
        else $error("write strobe without chip enable");
    a_no_clash: assert property (!(!flash_we_n && !flash_oe_n))
        else $error("write and read strobes together");
    a_write_held: assert property (!flash_we_n |-> !flash_dq_oe_n && $stable(flash_addr) && $stable(flash_dq_out))
        else $error("write cycle not held");
    a_read_floats: assert property (!flash_oe_n |-> flash_dq_oe_n)
        else $error("data driven during read");
    a_we_one_clk: assert property ($fell(flash_we_n) |=> flash_we_n)
        else $error("write pulse length");
    a_read_timing: assert property ($fell(flash_oe_n) |=> read_strobe)
        else $error("read strobe timing");
    a_rsp_status: assert property (rsp_valid |-> rsp_protected == !rsp_data[0])
        else $error("status bit sense");
    a_order_taken: assert property (cmd_valid && cmd_ready |=> busy)
        else $error("order not taken");
    a_rsp_from_read: assert property (rsp_valid |-> $past(!flash_oe_n) && busy == !cmd_ready)
        else $error("answer without read");
endmodule // flash_host_seq_monitor

bind flash_host_seq flash_host_seq_monitor u_mon (.mclk, .rst, .cmd_valid, .cmd_ready, .rsp_valid,
    .rsp_protected, .busy, .rsp_data, .flash_dq_out, .flash_addr, .flash_dq_oe_n, .flash_ce_n,
    .flash_we_n, .flash_oe_n);

// >>> dv/test_flash_host_seq.sv
/* Self-checking bench for the host sequencer against a device model.
   Assumes the design and checker files are compiled before it. */
`timescale 1ns/1ns
module test_flash_host_seq
    import flash_host_pkg::*;
;
    localparam logic [DATA_W-1:0] MAKER = 16'h00c3; // Arbitrary maker code
    logic mclk = 0, rst = 1, cmd_valid = 0, store_wr_en = 0;
    op_t  cmd_op = OP_READ;
    logic [ADDR_W-1:0] cmd_addr = '0, flash_addr;
    logic [DATA_W-1:0] cmd_data = '0, store_wr_data = '0, rsp_data, flash_dq_out, flash_dq_in, dev_dq;
    logic [IDX_W-1:0]  cmd_count = '0, store_wr_idx = '0;
    logic cmd_ready, rsp_valid, rsp_protected, busy, flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
    int num_errors = 0, checks = 0, i, j;
    logic [31:0] seed = 32'h43ff74ba, a;
    logic [3:0]  n;
    logic [DATA_W-1:0] pw [4];
    logic [DATA_W-1:0] rq [$];

    flash_host_seq u_dut (.mclk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .cmd_count,
        .store_wr_en, .store_wr_idx, .store_wr_data, .rsp_valid, .rsp_data, .rsp_protected, .busy,
        .flash_addr, .flash_dq_out, .flash_dq_in, .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n);
    flash_dev_model #(.MAKER(MAKER)) u_dev (.addr(flash_addr), .din(flash_dq_in), .dout(dev_dq),
        .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n));
    // Wire level from the host's drive enable
    assign flash_dq_in = flash_dq_oe_n ? dev_dq : flash_dq_out;

    initial forever #20 mclk = ~mclk;
    // Collect every read answer
    always @(negedge mclk) if (rsp_valid === 1'b1) rq.push_back(rsp_data);
    initial begin #2000000; num_errors++; test_done(); end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [DATA_W-1:0] arr(input logic [31:0] x);
        return x[15:0] ^ 16'h5a5a;
    endfunction
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pop(input logic [DATA_W-1:0] exp);
        chk(rq.size() > 0 ? rq.pop_front() : 16'hxxxx, exp);
    endtask
    task automatic st(input int k, input logic [DATA_W-1:0] d);
        @(negedge mclk);
        {store_wr_en, store_wr_idx, store_wr_data} = {1'b1, 4'(k), d};
        @(negedge mclk);
        store_wr_en = 0;
    endtask
    task automatic run(input op_t op, input logic [31:0] ad, input logic [DATA_W-1:0] d = 0,
                       input logic [3:0] cnt = 0);
        int t;
        @(negedge mclk);
        cmd_op = op;
        {cmd_addr, cmd_data, cmd_count, cmd_valid} = {ad[21:0], d, cnt, 1'b1};
        @(negedge mclk);
        cmd_valid = 0;
        for (t = 0; t < 400 && busy !== 1'b0; t++) @(negedge mclk);
        chk({15'h0, busy}, 16'h0);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge mclk);
        rst = 0;
        for (i = 0; i < 5; i++) begin a = xs(); run(OP_READ, a); pop(arr(a)); end
        run(OP_FREEZE_READ, 0); pop(16'h0001); chk({15'h0, rsp_protected}, 16'h0);
        run(OP_FREEZE_SET, 0);
        run(OP_FREEZE_READ, 0); pop(16'h0000); chk({15'h0, rsp_protected}, 16'h1);
        run(OP_READ, a); pop(arr(a));
        $display("freeze test finished");
        a = xs();
        run(OP_DYN_PROTECT, a); run(OP_DYN_READ, {a[21:15], ~a[14:0]}); pop(16'h0000);
        run(OP_DYN_UNPROTECT, a); run(OP_DYN_READ, a); pop(16'h0001);
        $display("dynamic test finished");
        for (i = 0; i < 4; i++) begin a = xs(); pw[i] = {a[15:8], 8'h3c}; st(i, pw[i]); end
        for (i = 3; i >= 0; i--) run(OP_PWD_PROGRAM, i, pw[i]);
        run(OP_PWD_READ, 0); for (i = 0; i < 4; i++) pop(pw[i]);
        run(OP_PWD_UNLOCK, 0); chk({15'h0, u_dev.ok}, 16'h1);
        st(2, ~pw[2]); run(OP_PWD_UNLOCK, 0); chk({15'h0, u_dev.ok}, 16'h0);
        $display("password test finished");
        run(OP_AUTOSEL_READ, 0); pop(MAKER);
        a = xs(); run(OP_SECURE_ENTER, 0); run(OP_READ, a); pop(~a[15:0]);
        run(OP_SECURE_EXIT, 0); run(OP_READ, a); pop(arr(a));
        run(OP_SECURE_ENTER, 0); run(OP_RESET, 0); run(OP_READ, a); pop(arr(a));
        run(OP_SECURE_ENTER, 0); run(OP_BUF_ABORT_RESET, 0); run(OP_READ, a); pop(arr(a));
        $display("mode test finished");
        for (i = 0; i < 3; i++) begin
            a = xs();
            n = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : a[3:0];
            for (j = 0; j <= n; j++) st(j, {a[j+:8], 8'h6b});
            run(OP_BUF_PROGRAM, a, 0, n); chk(16'(u_dev.done_n), 16'(n) + 16'h1);
            run(OP_READ, a); pop(arr(a));
        end
        $display("buffer test finished");
        test_done();
    end
endmodule // test_flash_host_seq
